// [inc/frs_cfg.svh]
/*
 * Constants of the fault status reporting block: register selects, bit
 * positions, reset values and timing.
 * Assumes it is included by its bare name from the package and the top module.
 */
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH

// Register select codes on the host register port
`define FRS_SEL_COND       3'h0
`define FRS_SEL_RISE       3'h1
`define FRS_SEL_FALL       3'h2
`define FRS_SEL_EVENT      3'h3
`define FRS_SEL_ENABLE     3'h4
`define FRS_SEL_STD_EVENT  3'h5

// Bit positions in the fault status word
`define FRS_BIT_CURRENT    0
`define FRS_BIT_VOLTAGE    1
`define FRS_BIT_POWER      2
`define FRS_BIT_REVERSE    3
`define FRS_BIT_THERMAL    4
`define FRS_BIT_SINK       5
`define FRS_BIT_SHORTED    6
`define FRS_BIT_LIM_RESULT 7
`define FRS_BIT_LIM_ACTIVE 8
`define FRS_BIT_COOLING    12
`define FRS_BIT_SENSE      13
`define FRS_BIT_SEQUENCE   14

// Defined bits of the fault status word
`define FRS_VALID_MASK     16'h71FF

// Reset values
`define FRS_RISE_RST       16'h71FF
`define FRS_FALL_RST       16'h0000
`define FRS_ENABLE_RST     16'h0000
`define FRS_WORD_RST       16'h0000
`define FRS_STD_RST        8'h00

// Fan recheck time after a protection clear
`define FRS_FAN_RECHECK_MS 1000
`define FRS_CLK_MHZ        100

`endif

// [inc/frs_pkg.sv]
/*
 * Types of the fault status reporting block.
 * Assumes frs_cfg.svh is on the include path.
 */
`include "frs_cfg.svh"

package frs_pkg;

    typedef enum logic [2:0] {
        FRS_REG_COND      = `FRS_SEL_COND,
        FRS_REG_RISE      = `FRS_SEL_RISE,
        FRS_REG_FALL      = `FRS_SEL_FALL,
        FRS_REG_EVENT     = `FRS_SEL_EVENT,
        FRS_REG_ENABLE    = `FRS_SEL_ENABLE,
        FRS_REG_STD_EVENT = `FRS_SEL_STD_EVENT
    } frs_sel_e;

    typedef logic [15:0] frs_word_t;

    // Instrument-wide conditions that are not per channel
    typedef struct packed {
        logic limit_pass;
        logic limit_enabled;
        logic sense_connected;
        logic program_running;
    } frs_misc_s;

    // Host register access request
    typedef struct packed {
        logic      wr_stb;
        logic      rd_stb;
        frs_sel_e  sel;
        frs_word_t wdata;
    } frs_req_s;

endpackage

// [design/frs_top.sv]
/*
 * Fault status reporting: condition, rise and fall filters, clear-on-read
 * event, enable mask and summary bit, plus a rise-only standard event word.
 * Assumes fault and activity inputs come from pins (synchronised here), while
 * the register request and protection clear come from logic on mclk_i.
 */
// What this block does
// - Condition word shows present monitored state; reading never alters it.
// - Event bit sets only on a filter-selected rise or fall of its condition.
// - Rise and fall filter selections are host-writable per bit.
// - Standard event word latches only rising source edges; no filters.
// - Reading an event word returns it, then clears it; a bit set by a transition in the read cycle stays set.
// - OR of enabled fault events drives the fault summary bit.
// - Excess current flag latches on any channel; clears when gone plus clear.
// - Excess voltage flag latches on any channel; clears when gone plus clear.
// - Excess power flag latches on any channel; clears when gone plus clear.
// - Reverse polarity flag latches on any channel; clears when gone plus clear.
// - Thermal trip latches and switches channel off until cooled plus clear.
// - Sink active flag is OR of all channel load-on states.
// - Input shorted flag is set while any channel is shorted.
// - Limit check result reads one on pass, zero on fail, while active.
// - Limit check active follows whether limit checking is enabled.
// - Cooling fault sets on fan failure; clear drops it, recheck resets it.
// - Sense lead flag follows remote sense connection.
// - Sequence running flag follows stored program execution.
`timescale 1ns/1ps
`include "frs_cfg.svh"

module frs_top #(
    parameter int NCH                = 4,
    parameter int NMOD               = 2,
    parameter int STDW               = 8,
    parameter int FAN_RECHECK_CYCLES = `FRS_FAN_RECHECK_MS * 1000 * `FRS_CLK_MHZ
) (
    input  wire logic               mclk_i,
    input  wire logic               reset_n_i,
    input  wire logic [NCH-1:0]     over_current_i,
    input  wire logic [NCH-1:0]     over_voltage_i,
    input  wire logic [NCH-1:0]     over_power_i,
    input  wire logic [NCH-1:0]     reverse_voltage_i,
    input  wire logic [NCH-1:0]     over_temp_i,
    input  wire logic [NCH-1:0]     load_on_i,
    input  wire logic [NCH-1:0]     short_on_i,
    input  wire logic [NMOD-1:0]    fan_fail_i,
    input  wire frs_pkg::frs_misc_s misc_i,
    input  wire logic               protection_clear_command_i,
    input  wire logic [STDW-1:0]    std_source_i,
    input  wire frs_pkg::frs_req_s  req_i,
    output logic [15:0]             rd_data_o,
    output logic                    rd_valid_o,
    output logic                    fault_summary_bit_o,
    output logic [NCH-1:0]          channel_off_o
);

    localparam int RAWW = 7 * NCH + NMOD + 4;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [RAWW-1:0] raw_in;
    logic [RAWW-1:0] sync1_q;
    logic [RAWW-1:0] sync2_q;

    assign raw_in = {misc_i, fan_fail_i, short_on_i, load_on_i, over_temp_i,
                     reverse_voltage_i, over_power_i, over_voltage_i, over_current_i};

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic [NCH-1:0]     s_oc;
    logic [NCH-1:0]     s_ov;
    logic [NCH-1:0]     s_op;
    logic [NCH-1:0]     s_rv;
    logic [NCH-1:0]     s_ot;
    logic [NCH-1:0]     s_load;
    logic [NCH-1:0]     s_short;
    logic [NMOD-1:0]    s_fan;
    frs_pkg::frs_misc_s s_misc;

    assign s_oc    = sync2_q[0*NCH +: NCH];
    assign s_ov    = sync2_q[1*NCH +: NCH];
    assign s_op    = sync2_q[2*NCH +: NCH];
    assign s_rv    = sync2_q[3*NCH +: NCH];
    assign s_ot    = sync2_q[4*NCH +: NCH];
    assign s_load  = sync2_q[5*NCH +: NCH];
    assign s_short = sync2_q[6*NCH +: NCH];
    assign s_fan   = sync2_q[7*NCH +: NMOD];
    assign s_misc  = sync2_q[7*NCH+NMOD +: 4];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Transition filter shared by the fault and standard event words
    function automatic logic [15:0] edge_hits(input logic [15:0] now, input logic [15:0] was,
                                              input logic [15:0] rise, input logic [15:0] fall);
        edge_hits = (rise & now & ~was) | (fall & ~now & was);
    endfunction

    function automatic logic is_access(input frs_pkg::frs_req_s r, input frs_pkg::frs_sel_e s);
        is_access = r.sel == s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [15:0]     cond_q;
    logic [15:0]     cond_d;
    logic [15:0]     rise_q;
    logic [15:0]     rise_d;
    logic [15:0]     fall_q;
    logic [15:0]     fall_d;
    logic [15:0]     event_q;
    logic [15:0]     event_d;
    logic [15:0]     enable_q;
    logic [15:0]     enable_d;
    logic [STDW-1:0] std_prev_q;
    logic [STDW-1:0] std_prev_d;
    logic [STDW-1:0] std_event_q;
    logic [STDW-1:0] std_event_d;
    logic [31:0]     fan_cnt_q;
    logic [31:0]     fan_cnt_d;
    logic [NCH-1:0]  chan_off_q;
    logic [NCH-1:0]  chan_off_d;
    logic [15:0]     rd_data_q;
    logic [15:0]     rd_data_d;
    logic            rd_valid_q;
    logic            rd_valid_d;
    logic            summary_q;
    logic            summary_d;
    logic [4:0]      prot_any;
    logic [15:0]     new_events;
    logic [15:0]     std_hits;
    logic            clr;
    logic            wr;
    logic            rd;

    always_comb begin
        clr = protection_clear_command_i;
        wr  = req_i.wr_stb;
        rd  = req_i.rd_stb;
        prot_any = {|s_ot, |s_rv, |s_op, |s_ov, |s_oc};
        cond_d = `FRS_WORD_RST;
        // Protection flags: a live fault wins over a clear arriving with it
        cond_d[4:0] = prot_any | (cond_q[4:0] & {5{~clr}});
        cond_d[`FRS_BIT_SINK]       = |s_load;
        cond_d[`FRS_BIT_SHORTED]    = |s_short;
        cond_d[`FRS_BIT_LIM_RESULT] = s_misc.limit_enabled & s_misc.limit_pass;
        cond_d[`FRS_BIT_LIM_ACTIVE] = s_misc.limit_enabled;
        cond_d[`FRS_BIT_SENSE]      = s_misc.sense_connected;
        cond_d[`FRS_BIT_SEQUENCE]   = s_misc.program_running;
        // Clear drops the fan flag; it returns after the recheck time if the fan is still bad
        fan_cnt_d = fan_cnt_q;
        if (clr) begin
            fan_cnt_d = FAN_RECHECK_CYCLES[31:0];
        end else if (fan_cnt_q != 32'h0000_0000) begin
            fan_cnt_d = fan_cnt_q - 32'h0000_0001;
        end
        cond_d[`FRS_BIT_COOLING] = ~clr & (cond_q[`FRS_BIT_COOLING] |
                                           ((|s_fan) & (fan_cnt_q == 32'h0000_0000)));
        cond_d = cond_d & `FRS_VALID_MASK;
        chan_off_d = s_ot | (chan_off_q & {NCH{~clr}});

        rise_d   = (wr && is_access(req_i, frs_pkg::FRS_REG_RISE)) ?
                   (req_i.wdata & `FRS_VALID_MASK) : rise_q;
        fall_d   = (wr && is_access(req_i, frs_pkg::FRS_REG_FALL)) ?
                   (req_i.wdata & `FRS_VALID_MASK) : fall_q;
        enable_d = (wr && is_access(req_i, frs_pkg::FRS_REG_ENABLE)) ?
                   (req_i.wdata & `FRS_VALID_MASK) : enable_q;

        // A transition landing in the read cycle survives the clear
        new_events = edge_hits(cond_d, cond_q, rise_q, fall_q) & `FRS_VALID_MASK;
        event_d = ((rd && is_access(req_i, frs_pkg::FRS_REG_EVENT)) ? 16'h0000 : event_q) |
                  new_events;
        summary_d = |(event_d & enable_d);

        std_prev_d = std_source_i;
        std_hits   = edge_hits({{(16-STDW){1'b0}}, std_source_i}, {{(16-STDW){1'b0}}, std_prev_q},
                               16'hFFFF, 16'h0000);
        std_event_d = ((rd && is_access(req_i, frs_pkg::FRS_REG_STD_EVENT)) ? {STDW{1'b0}} :
                       std_event_q) | std_hits[STDW-1:0];

        // Reads see the word before any clear; condition reads change nothing
        rd_valid_d = rd;
        case (req_i.sel)
            frs_pkg::FRS_REG_COND:      rd_data_d = cond_q;
            frs_pkg::FRS_REG_RISE:      rd_data_d = rise_q;
            frs_pkg::FRS_REG_FALL:      rd_data_d = fall_q;
            frs_pkg::FRS_REG_EVENT:     rd_data_d = event_q;
            frs_pkg::FRS_REG_ENABLE:    rd_data_d = enable_q;
            frs_pkg::FRS_REG_STD_EVENT: rd_data_d = {{(16-STDW){1'b0}}, std_event_q};
            default:                    rd_data_d = 16'h0000;
        endcase
        if (!rd) begin
            rd_data_d = rd_data_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cond_q      <= `FRS_WORD_RST;
            rise_q      <= `FRS_RISE_RST;
            fall_q      <= `FRS_FALL_RST;
            event_q     <= `FRS_WORD_RST;
            enable_q    <= `FRS_ENABLE_RST;
            std_prev_q  <= '0;
            std_event_q <= '0;
            fan_cnt_q   <= 32'h0000_0000;
            chan_off_q  <= '0;
            rd_data_q   <= 16'h0000;
            rd_valid_q  <= 1'b0;
            summary_q   <= 1'b0;
        end else begin
            cond_q      <= cond_d;
            rise_q      <= rise_d;
            fall_q      <= fall_d;
            event_q     <= event_d;
            enable_q    <= enable_d;
            std_prev_q  <= std_prev_d;
            std_event_q <= std_event_d;
            fan_cnt_q   <= fan_cnt_d;
            chan_off_q  <= chan_off_d;
            rd_data_q   <= rd_data_d;
            rd_valid_q  <= rd_valid_d;
            summary_q   <= summary_d;
        end
    end

    assign rd_data_o           = rd_data_q;
    assign rd_valid_o          = rd_valid_q;
    assign fault_summary_bit_o = summary_q;
    assign channel_off_o       = chan_off_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence ev_read_s;
        rd_valid_o && (rd_data_o == $past(event_q));
    endsequence

    cond_read_a: assert property ((rd && req_i.sel == frs_pkg::FRS_REG_COND) |=>
        rd_valid_o && rd_data_o == $past(cond_q))
        else $error("condition read returned wrong word");
    edge_only_a: assert property (1 |=> ((event_q & ~$past(event_q)) &
        ~edge_hits(cond_q, $past(cond_q), $past(rise_q), $past(fall_q))) == 16'h0000)
        else $error("event bit set without selected transition");
    edge_caught_a: assert property (1 |=> (edge_hits(cond_q, $past(cond_q), $past(rise_q),
        $past(fall_q)) & ~event_q) == 16'h0000)
        else $error("selected transition not latched");
    filter_write_a: assert property ((wr && req_i.sel == frs_pkg::FRS_REG_FALL) |=>
        fall_q == ($past(req_i.wdata) & `FRS_VALID_MASK))
        else $error("fall filter write lost");
    rise_write_a: assert property ((wr && req_i.sel == frs_pkg::FRS_REG_RISE) |=>
        rise_q == ($past(req_i.wdata) & `FRS_VALID_MASK))
        else $error("rise filter write lost");
    std_rise_a: assert property (1 |=> ((std_event_q & ~$past(std_event_q)) &
        ~($past(std_source_i) & ~$past(std_prev_q))) == '0)
        else $error("standard event set without rising edge");
    read_clear_a: assert property ((rd && req_i.sel == frs_pkg::FRS_REG_EVENT) |=>
        ev_read_s and ((event_q & ~edge_hits(cond_q, $past(cond_q), $past(rise_q),
        $past(fall_q))) == 16'h0000))
        else $error("event read did not return and clear");
    summary_or_a: assert property (fault_summary_bit_o == |(event_q & enable_q))
        else $error("summary bit disagrees with enabled events");
    current_hold_a: assert property (cond_q[`FRS_BIT_CURRENT] && !clr |=>
        cond_q[`FRS_BIT_CURRENT])
        else $error("excess current flag dropped without clear");
    prot_set_a: assert property (1 |=> (cond_q[4:0] & $past(prot_any)) == $past(prot_any))
        else $error("protection flag missed a fault");
    flag_release_a: assert property (1 |=> (($past(cond_q) & ~cond_q) & 16'h001F &
        ~{11'h000, {5{$past(clr)}} & ~$past(prot_any)}) == 16'h0000)
        else $error("protection flag dropped without clear");
    thermal_off_a: assert property (1 |=> (($past(s_ot) & ~channel_off_o) == '0) &&
        (channel_off_o != '0 || !cond_q[`FRS_BIT_THERMAL] || $past(clr) || $past(s_ot) == '0))
        else $error("hot channel not switched off");
    live_flags_a: assert property (1 |=> cond_q[`FRS_BIT_SINK] == |$past(s_load) &&
        cond_q[`FRS_BIT_SHORTED] == |$past(s_short) &&
        cond_q[`FRS_BIT_SENSE] == $past(s_misc.sense_connected) &&
        cond_q[`FRS_BIT_SEQUENCE] == $past(s_misc.program_running))
        else $error("live status flag wrong");
    limit_pair_a: assert property (cond_q[`FRS_BIT_LIM_RESULT] |-> cond_q[`FRS_BIT_LIM_ACTIVE])
        else $error("limit result set while checking inactive");
    fan_clear_a: assert property (clr |=> !cond_q[`FRS_BIT_COOLING] && fan_cnt_q != 32'h0000_0000)
        else $error("cooling fault not cleared by protection clear");
    fan_recheck_a: assert property (!clr && fan_cnt_q == 32'h0000_0000 && (|s_fan) |=>
        cond_q[`FRS_BIT_COOLING])
        else $error("cooling fault not raised for failed fan");
    undef_zero_a: assert property (((cond_q | rise_q | fall_q | event_q | enable_q) &
        ~`FRS_VALID_MASK) == 16'h0000)
        else $error("undefined status bit is set");

endmodule

// [verif/tb_frs_top.sv]
/*
 * Self-checking testbench of the fault status reporting block: register
 * reads and writes, fault latching and protection clear, follow-through
 * flags, fan recheck, clear-on-read and the rise-only standard event word.
 * Assumes frs_cfg.svh and frs_pkg are compiled first; no other models needed.
 */
`timescale 1ns/1ps

module tb_frs_top;

    localparam int NCH     = 4;
    localparam int RECHECK = 16;

    logic               mclk_i;
    logic               reset_n_i;
    logic [NCH-1:0]     flt [0:4];
    logic [NCH-1:0]     load_on;
    logic [NCH-1:0]     short_on;
    logic [1:0]         fan_fail;
    frs_pkg::frs_misc_s misc;
    logic               prot_clear;
    logic [7:0]         std_src;
    frs_pkg::frs_req_s  req;
    logic [15:0]        rd_data;
    logic               rd_valid;
    logic               summary;
    logic [NCH-1:0]     chan_off;
    logic [15:0]        bitv;
    int                 mismatches;
    int                 num_checks;

    ////////////////////////////////////////////////////////////////////////////

    frs_top #(
        .NCH                (NCH),
        .NMOD               (2),
        .STDW               (8),
        .FAN_RECHECK_CYCLES (RECHECK)
    ) u_frs_top (
        .mclk_i                     (mclk_i),
        .reset_n_i                  (reset_n_i),
        .over_current_i             (flt[0]),
        .over_voltage_i             (flt[1]),
        .over_power_i               (flt[2]),
        .reverse_voltage_i          (flt[3]),
        .over_temp_i                (flt[4]),
        .load_on_i                  (load_on),
        .short_on_i                 (short_on),
        .fan_fail_i                 (fan_fail),
        .misc_i                     (misc),
        .protection_clear_command_i (prot_clear),
        .std_source_i               (std_src),
        .req_i                      (req),
        .rd_data_o                  (rd_data),
        .rd_valid_o                 (rd_valid),
        .fault_summary_bit_o        (summary),
        .channel_off_o              (chan_off)
    );

    always #5 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////////

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every task that drives inputs is entered just after a falling edge, so inputs never race the sampling edge
    task automatic wr(input frs_pkg::frs_sel_e sel, input logic [15:0] data);
        req.wr_stb = 1'b1;
        req.sel    = sel;
        req.wdata  = data;
        @(negedge mclk_i);
        req.wr_stb = 1'b0;
        @(negedge mclk_i);
    endtask

    task automatic rd(input frs_pkg::frs_sel_e sel, input logic [15:0] exp, input string what);
        req.rd_stb = 1'b1;
        req.sel    = sel;
        @(negedge mclk_i);
        req.rd_stb = 1'b0;
        chk({what, " valid"}, {15'h0000, rd_valid}, 16'h0001);
        chk(what, rd_data, exp);
        @(negedge mclk_i);
        chk({what, " pulse"}, {15'h0000, rd_valid}, 16'h0000);
    endtask

    task automatic clr();
        prot_clear = 1'b1;
        @(negedge mclk_i);
        prot_clear = 1'b0;
    endtask

    // Two synchroniser stages plus the register, with margin
    task automatic settle();
        repeat (5) @(negedge mclk_i);
    endtask

    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        test_done();
    end

    initial begin
        mclk_i     = 1'b0;
        reset_n_i  = 1'b0;
        for (int i = 0; i < 5; i++) begin
            flt[i] = '0;
        end
        load_on    = '0;
        short_on   = '0;
        fan_fail   = 2'h0;
        misc       = 4'h0;
        prot_clear = 1'b0;
        std_src    = 8'h00;
        req        = '0;
        mismatches = 0;
        num_checks = 0;
        repeat (4) @(negedge mclk_i);
        reset_n_i = 1'b1;
        rd(frs_pkg::FRS_REG_COND, 16'h0000, "cond reset");
        rd(frs_pkg::FRS_REG_RISE, 16'h71FF, "rise reset");
        rd(frs_pkg::FRS_REG_FALL, 16'h0000, "fall reset");
        rd(frs_pkg::FRS_REG_EVENT, 16'h0000, "event reset");
        rd(frs_pkg::FRS_REG_ENABLE, 16'h0000, "enable reset");
        rd(frs_pkg::FRS_REG_STD_EVENT, 16'h0000, "std reset");
        rd(frs_pkg::frs_sel_e'(3'h6), 16'h0000, "unmapped");
        wr(frs_pkg::FRS_REG_RISE, 16'hFFFF);
        rd(frs_pkg::FRS_REG_RISE, 16'h71FF, "rise holes");
        wr(frs_pkg::FRS_REG_FALL, 16'hFFFF);
        rd(frs_pkg::FRS_REG_FALL, 16'h71FF, "fall holes");
        wr(frs_pkg::FRS_REG_COND, 16'hFFFF);
        rd(frs_pkg::FRS_REG_COND, 16'h0000, "cond read only");
        // Fall filter only on the latched protection bits
        wr(frs_pkg::FRS_REG_FALL, 16'h001F);
        wr(frs_pkg::FRS_REG_ENABLE, 16'h001F);
        for (int i = 0; i < 5; i++) begin
            bitv = 16'h0001 << i;
            flt[i][i % NCH] = 1'b1;
            settle();
            rd(frs_pkg::FRS_REG_COND, bitv, "flag set");
            chk("summary", {15'h0000, summary}, 16'h0001);
            chk("chan off", {12'h000, chan_off}, (i == 4) ? 16'h0001 : 16'h0000);
            rd(frs_pkg::FRS_REG_EVENT, bitv, "event rise");
            rd(frs_pkg::FRS_REG_EVENT, 16'h0000, "event cleared");
            clr();
            settle();
            rd(frs_pkg::FRS_REG_COND, bitv, "clear refused");
            flt[i] = '0;
            settle();
            rd(frs_pkg::FRS_REG_COND, bitv, "flag held");
            clr();
            settle();
            rd(frs_pkg::FRS_REG_COND, 16'h0000, "flag cleared");
            rd(frs_pkg::FRS_REG_EVENT, bitv, "event fall");
            chk("chan on", {12'h000, chan_off}, 16'h0000);
        end
        wr(frs_pkg::FRS_REG_ENABLE, 16'h0040);
        load_on  = 4'h8;
        short_on = 4'h2;
        misc     = 4'hF;
        settle();
        rd(frs_pkg::FRS_REG_COND, 16'h61E0, "follow set");
        rd(frs_pkg::FRS_REG_COND, 16'h61E0, "cond reread");
        chk("summary masked in", {15'h0000, summary}, 16'h0001);
        rd(frs_pkg::FRS_REG_EVENT, 16'h61E0, "follow events");
        @(negedge mclk_i);
        chk("summary after read", {15'h0000, summary}, 16'h0000);
        misc.limit_pass = 1'b0;
        settle();
        rd(frs_pkg::FRS_REG_COND, 16'h6160, "limit fail");
        misc     = 4'h0;
        load_on  = '0;
        short_on = '0;
        settle();
        rd(frs_pkg::FRS_REG_COND, 16'h0000, "follow clear");
        rd(frs_pkg::FRS_REG_EVENT, 16'h0000, "unfiltered fall");
        wr(frs_pkg::FRS_REG_RISE, 16'h61FF);
        fan_fail = 2'h2;
        settle();
        rd(frs_pkg::FRS_REG_COND, 16'h1000, "fan set");
        rd(frs_pkg::FRS_REG_EVENT, 16'h0000, "rise masked");
        clr();
        rd(frs_pkg::FRS_REG_COND, 16'h0000, "fan cleared");
        repeat (RECHECK + 4) @(negedge mclk_i);
        rd(frs_pkg::FRS_REG_COND, 16'h1000, "fan recheck");
        fan_fail = 2'h0;
        settle();
        clr();
        settle();
        rd(frs_pkg::FRS_REG_COND, 16'h0000, "fan gone");
        std_src = 8'h81;
        @(negedge mclk_i);
        rd(frs_pkg::FRS_REG_STD_EVENT, 16'h0081, "std rise");
        std_src = 8'h00;
        @(negedge mclk_i);
        rd(frs_pkg::FRS_REG_STD_EVENT, 16'h0000, "std no fall");
        test_done();
    end

endmodule
